// *** pkg/fts_consts.svh ***
// Offsets, field positions, reset values and timing of the flash sync control block
`ifndef FTS_CONSTS_SVH
`define FTS_CONSTS_SVH

`define FTS_CLK_HZ 50000000
`define FTS_MS_PER_SEC 1000
`define FTS_TIMEOUT_STEP_MS 32
`define FTS_CYCLES_PER_MS (`FTS_CLK_HZ / `FTS_MS_PER_SEC)

`define FTS_ADDR_CONTROL 8'h00
`define FTS_ADDR_CONFIG1 8'h04
`define FTS_ADDR_TORCH_LEVEL 8'h08
`define FTS_ADDR_FLASH_LEVEL 8'h0C
`define FTS_ADDR_FLASH_DURATION 8'h10
`define FTS_ADDR_FLAGS 8'h14
`define FTS_ADDR_REDUCED_LEVEL 8'h18
`define FTS_ADDR_STATUS 8'h1C

`define FTS_CTL_FLASH_GO 0
`define FTS_CTL_TORCH_EN 1
`define FTS_CTL_MON_EN 2

`define FTS_CFG_POLARITY 5
`define FTS_CFG_HW_TORCH 7

`define FTS_FLG_TIMEOUT 0
`define FTS_FLG_LED_HOT 1
`define FTS_FLG_LED_FAIL 2
`define FTS_FLG_THERMAL 3
`define FTS_FLG_UNDERVOLT 4
`define FTS_FLG_SYNC_A 5
`define FTS_FLG_FLASH_MON 6
`define FTS_FLG_SYNC_B 7

`define FTS_RST_CONTROL 8'h00
`define FTS_RST_CONFIG1 8'h20
`define FTS_RST_TORCH_LEVEL 8'h11
`define FTS_RST_FLASH_LEVEL 8'h88
`define FTS_RST_FLASH_DURATION 8'h0F
`define FTS_RST_REDUCED_LEVEL 8'h44

`define FTS_DUR_LSB 0
`define FTS_DUR_MSB 4
`define FTS_MS_CNT_W 11

`endif

// *** pkg/fts_pkg.sv ***
// Types and shared decoding for the flash sync control block
package fts_pkg;

    typedef enum logic [1:0] {
        FTS_ST_IDLE,
        FTS_ST_TORCH,
        FTS_ST_FLASH
    } fts_state_type;

    // Flash timeout in ms for a five-bit duration code: (code + 1) steps of 32 ms
    function automatic logic [10:0] fts_timeout_ms(input logic [4:0] code);
        logic [10:0] steps;
        steps = {6'h00, code} + 11'h001;
        return steps << 5;
    endfunction : fts_timeout_ms

endpackage : fts_pkg

// *** design/fts_sync2.sv ***
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ns
module fts_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic [WIDTH-1:0] async_in, // Levels from pins
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : fts_sync2

// *** design/fts_tick_div.sv ***
// Divider giving a one-cycle enable pulse every CYCLES clock cycles
`timescale 1ns/1ns
`include "fts_consts.svh"
module fts_tick_div #(
    parameter int unsigned CYCLES = `FTS_CYCLES_PER_MS
) (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic clear, // Restart the period
    output logic tick // One-cycle pulse at end of each period
);
    logic [31:0] cnt_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (clear) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_r == 32'(CYCLES - 1)) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule : fts_tick_div

// *** design/fts_flash_ctrl.sv ***
// Flash sync control: register file, flash timing, sync reduction and fault flags
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "fts_consts.svh"
module fts_flash_ctrl #(
    parameter int unsigned CYCLES_PER_MS = `FTS_CYCLES_PER_MS,
    parameter int LEVEL_W = 8
) (
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic hardware_enable_pin, // Device enable pin, active high
    input wire logic multi_function_pin_a, // Sync input A or torch enable
    input wire logic pa_sync_input_b, // Sync input B
    input wire logic led_overtemp_in, // LED overtemperature comparator
    input wire logic led_fail_in, // LED short or output overvoltage
    input wire logic thermal_shutdown_in, // Die thermal shutdown
    input wire logic supply_undervolt_in, // Supply below monitor threshold
    input wire logic supply_below_flash_th_in, // Supply below supply_flash_threshold
    output logic current_source_a_en, // Source A on
    output logic [LEVEL_W-1:0] current_source_a_level, // Source A current code
    output logic current_source_b_en, // Source B on
    output logic [LEVEL_W-1:0] current_source_b_level, // Source B current code
    output logic flash_active // Flash pulse in progress
);
    localparam int HALF = LEVEL_W / 2;

    logic [7:0] pins_s;
    logic hardware_enable_pin_s;
    logic pin_a_s;
    logic pin_b_s;
    logic led_hot_s;
    logic led_fail_s;
    logic thermal_s;
    logic uv_s;
    logic flash_th_s;

    fts_sync2 #(.WIDTH(8)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in({supply_below_flash_th_in, supply_undervolt_in, thermal_shutdown_in,
                   led_fail_in, led_overtemp_in, pa_sync_input_b, multi_function_pin_a,
                   hardware_enable_pin}),
        .sync_out(pins_s)
    );

    assign {flash_th_s, uv_s, thermal_s, led_fail_s, led_hot_s, pin_b_s, pin_a_s, hardware_enable_pin_s} = pins_s;

    // Pin low acts like a synchronous reset of all control state except sync_a_act_r, sync_b_act_r and the bus answer (wb_ack_o, wb_dat_o)
    logic shut;
    assign shut = ~hardware_enable_pin_s;

    logic [7:0] control_r;
    logic [7:0] config1_r;
    logic [7:0] torch_level_r;
    logic [7:0] flash_level_r;
    logic [7:0] duration_r;
    logic [7:0] flags_r;
    logic [7:0] reduced_level_r;
    logic mon_latch_r;
    fts_pkg::fts_state_type state_r;
    fts_pkg::fts_state_type state_nxt;
    logic [`FTS_MS_CNT_W-1:0] ms_cnt_r;
    logic sync_a_act_r;
    logic sync_b_act_r;

    // Bus request taken on the first strobe cycle; ack follows one edge later
    logic bus_take;
    logic wr_take;
    logic rd_flags;
    assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_take = bus_take & wb_we_i & wb_sel_i[0];
    assign rd_flags = bus_take & ~wb_we_i & (wb_adr_i == `FTS_ADDR_FLAGS);

    logic flash_go;
    assign flash_go = wr_take & (wb_adr_i == `FTS_ADDR_CONTROL) & wb_dat_i[`FTS_CTL_FLASH_GO];

    // Sync interpretation
    logic hw_torch_mode;
    logic polarity_high;
    logic sync_a_act;
    logic sync_b_act;
    logic sync_any;
    assign hw_torch_mode = config1_r[`FTS_CFG_HW_TORCH];
    assign polarity_high = config1_r[`FTS_CFG_POLARITY];
    assign sync_a_act = ~hw_torch_mode & (polarity_high ? pin_a_s : ~pin_a_s);
    assign sync_b_act = polarity_high ? pin_b_s : ~pin_b_s;
    assign sync_any = sync_a_act | sync_b_act;

    logic ms_tick;
    fts_tick_div #(.CYCLES(CYCLES_PER_MS)) u_tick (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clear(state_r != fts_pkg::FTS_ST_FLASH),
        .tick(ms_tick)
    );

    logic [`FTS_MS_CNT_W-1:0] timeout_ms;
    logic timeout_hit;
    assign timeout_ms = fts_pkg::fts_timeout_ms(duration_r[`FTS_DUR_MSB:`FTS_DUR_LSB]);
    assign timeout_hit = (state_r == fts_pkg::FTS_ST_FLASH) & ms_tick &
                         (ms_cnt_r == timeout_ms - 11'h001);

    logic torch_req;
    assign torch_req = control_r[`FTS_CTL_TORCH_EN] | (hw_torch_mode & pin_a_s);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fts_pkg::FTS_ST_IDLE: begin
                if (flash_go) begin
                    state_nxt = fts_pkg::FTS_ST_FLASH;
                end else if (torch_req) begin
                    state_nxt = fts_pkg::FTS_ST_TORCH;
                end
            end
            fts_pkg::FTS_ST_TORCH: begin
                if (flash_go) begin
                    state_nxt = fts_pkg::FTS_ST_FLASH;
                end else if (!torch_req) begin
                    state_nxt = fts_pkg::FTS_ST_IDLE;
                end
            end
            fts_pkg::FTS_ST_FLASH: begin
                if (timeout_hit) begin
                    state_nxt = fts_pkg::FTS_ST_IDLE;
                end
            end
            default: state_nxt = fts_pkg::FTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= fts_pkg::FTS_ST_IDLE;
        end else if (shut) begin
            state_r <= fts_pkg::FTS_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_cnt_r <= '0;
        end else if (state_r != fts_pkg::FTS_ST_FLASH || shut) begin
            ms_cnt_r <= '0;
        end else if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 11'h001;
        end
    end

    // Writable registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_r <= `FTS_RST_CONTROL;
            config1_r <= `FTS_RST_CONFIG1;
            torch_level_r <= `FTS_RST_TORCH_LEVEL;
            flash_level_r <= `FTS_RST_FLASH_LEVEL;
            duration_r <= `FTS_RST_FLASH_DURATION;
            reduced_level_r <= `FTS_RST_REDUCED_LEVEL;
        end else if (shut) begin
            control_r <= `FTS_RST_CONTROL;
            config1_r <= `FTS_RST_CONFIG1;
            torch_level_r <= `FTS_RST_TORCH_LEVEL;
            flash_level_r <= `FTS_RST_FLASH_LEVEL;
            duration_r <= `FTS_RST_FLASH_DURATION;
            reduced_level_r <= `FTS_RST_REDUCED_LEVEL;
        end else begin
            // Hardware torch is one-shot: a flash ending in that mode disarms it
            if (timeout_hit && hw_torch_mode) begin
                config1_r[`FTS_CFG_HW_TORCH] <= 1'b0;
            end
            if (wr_take) begin
                if (wb_adr_i == `FTS_ADDR_CONTROL) begin
                    control_r <= {wb_dat_i[7:1], 1'b0};
                end else if (wb_adr_i == `FTS_ADDR_CONFIG1) begin
                    config1_r <= wb_dat_i[7:0];
                end else if (wb_adr_i == `FTS_ADDR_TORCH_LEVEL) begin
                    torch_level_r <= wb_dat_i[7:0];
                end else if (wb_adr_i == `FTS_ADDR_FLASH_LEVEL) begin
                    flash_level_r <= wb_dat_i[7:0];
                end else if (wb_adr_i == `FTS_ADDR_FLASH_DURATION) begin
                    duration_r <= wb_dat_i[7:0];
                end else if (wb_adr_i == `FTS_ADDR_REDUCED_LEVEL) begin
                    reduced_level_r <= wb_dat_i[7:0];
                end
            end
        end
    end

    // Flash monitor trip and its latched reduction
    logic mon_trip;
    assign mon_trip = control_r[`FTS_CTL_MON_EN] & flash_th_s &
                      (state_r == fts_pkg::FTS_ST_FLASH);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mon_latch_r <= 1'b0;
        end else if (shut) begin
            mon_latch_r <= 1'b0;
        end else begin
            // A trip in the read cycle wins over the clear
            mon_latch_r <= (mon_latch_r & ~rd_flags) | mon_trip;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a_act_r <= 1'b0;
            sync_b_act_r <= 1'b0;
        end else begin
            sync_a_act_r <= sync_a_act;
            sync_b_act_r <= sync_b_act;
        end
    end

    logic [7:0] flag_set;
    logic in_flash;
    assign in_flash = state_r == fts_pkg::FTS_ST_FLASH;

    always_comb begin
        flag_set = 8'h00;
        flag_set[`FTS_FLG_TIMEOUT] = timeout_hit;
        flag_set[`FTS_FLG_LED_HOT] = led_hot_s;
        flag_set[`FTS_FLG_LED_FAIL] = led_fail_s;
        flag_set[`FTS_FLG_THERMAL] = thermal_s;
        flag_set[`FTS_FLG_UNDERVOLT] = uv_s;
        flag_set[`FTS_FLG_SYNC_A] = in_flash & sync_a_act & ~sync_a_act_r;
        flag_set[`FTS_FLG_FLASH_MON] = mon_trip;
        flag_set[`FTS_FLG_SYNC_B] = in_flash & sync_b_act & ~sync_b_act_r;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= 8'h00;
        end else if (shut) begin
            flags_r <= 8'h00;
        end else begin
            flags_r <= (flags_r & ~{8{rd_flags}}) | flag_set;
        end
    end

    // Source drive
    logic [7:0] flash_eff;
    logic [7:0] drive_nxt;
    logic on_nxt;
    assign flash_eff = mon_latch_r ? reduced_level_r : flash_level_r;

    always_comb begin
        drive_nxt = 8'h00;
        on_nxt = 1'b0;
        case (state_nxt)
            fts_pkg::FTS_ST_TORCH: begin
                drive_nxt = torch_level_r;
                on_nxt = 1'b1;
            end
            fts_pkg::FTS_ST_FLASH: begin
                drive_nxt = sync_any ? torch_level_r : flash_eff;
                on_nxt = 1'b1;
            end
            default: begin
                drive_nxt = 8'h00;
                on_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            current_source_a_en <= 1'b0;
            current_source_b_en <= 1'b0;
            current_source_a_level <= '0;
            current_source_b_level <= '0;
            flash_active <= 1'b0;
        end else if (shut) begin
            current_source_a_en <= 1'b0;
            current_source_b_en <= 1'b0;
            current_source_a_level <= '0;
            current_source_b_level <= '0;
            flash_active <= 1'b0;
        end else begin
            current_source_a_en <= on_nxt;
            current_source_b_en <= on_nxt;
            current_source_a_level <= LEVEL_W'(drive_nxt[HALF-1:0]);
            current_source_b_level <= LEVEL_W'(drive_nxt[LEVEL_W-1:HALF]);
            flash_active <= state_nxt == fts_pkg::FTS_ST_FLASH;
        end
    end

    // Bus answer: one wait-free cycle, unmapped reads return zero
    logic [7:0] rd_byte;
    always_comb begin
        if (wb_adr_i == `FTS_ADDR_CONTROL) begin
            rd_byte = control_r;
        end else if (wb_adr_i == `FTS_ADDR_CONFIG1) begin
            rd_byte = config1_r;
        end else if (wb_adr_i == `FTS_ADDR_TORCH_LEVEL) begin
            rd_byte = torch_level_r;
        end else if (wb_adr_i == `FTS_ADDR_FLASH_LEVEL) begin
            rd_byte = flash_level_r;
        end else if (wb_adr_i == `FTS_ADDR_FLASH_DURATION) begin
            rd_byte = duration_r;
        end else if (wb_adr_i == `FTS_ADDR_FLAGS) begin
            rd_byte = flags_r;
        end else if (wb_adr_i == `FTS_ADDR_REDUCED_LEVEL) begin
            rd_byte = reduced_level_r;
        end else if (wb_adr_i == `FTS_ADDR_STATUS) begin
            rd_byte = {2'b00, hardware_enable_pin_s, sync_b_act, sync_a_act, mon_latch_r,
                       state_r == fts_pkg::FTS_ST_TORCH, in_flash};
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_take;
            if (bus_take && !wb_we_i) begin
                wb_dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end
endmodule : fts_flash_ctrl

// *** tb/fts_flash_ctrl_props.sv ***
// Concurrent checks on the ports of the flash sync control block
`timescale 1ns/1ns
`include "fts_consts.svh"
module fts_flash_ctrl_props #(
    parameter int unsigned CYCLES_PER_MS = 50000
) (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_o, // Wishbone read data
    input wire logic wb_ack_o, // Wishbone acknowledge
    input wire logic hardware_enable_pin, // Device enable pin
    input wire logic current_source_a_en, // Source A on
    input wire logic current_source_b_en, // Source B on
    input wire logic flash_active // Flash pulse in progress
);
    // Longest code plus slack for the divider and output register
    localparam int unsigned MAX_FLASH = 1024 * CYCLES_PER_MS + 4;
    logic [2:0] en_cnt_r;
    logic [31:0] fl_cnt_r;
    logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Writes only land after the enable pin has passed its synchroniser
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            en_cnt_r <= 3'h0;
        else if (!hardware_enable_pin)
            en_cnt_r <= 3'h0;
        else if (en_cnt_r != 3'h7)
            en_cnt_r <= en_cnt_r + 3'h1;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            fl_cnt_r <= 32'h00000000;
        else if (flash_active)
            fl_cnt_r <= fl_cnt_r + 32'h00000001;
        else
            fl_cnt_r <= 32'h00000000;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (take |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");
    chk_flash_both: assert property (flash_active |-> current_source_a_en && current_source_b_en)
        else $error("a source is off during flash");
    chk_shutdown_off: assert property (!hardware_enable_pin [*4] |->
        !current_source_a_en && !current_source_b_en && !flash_active)
        else $error("sources on while disabled");
    chk_flash_start: assert property (take && wb_we_i && wb_adr_i == `FTS_ADDR_CONTROL && wb_sel_i[0]
        && wb_dat_i[0] && !flash_active && en_cnt_r >= 3'h4 |=> flash_active)
        else $error("flash go did not start flash");
    chk_flash_cause: assert property ($rose(flash_active) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("flash started without a write");
    chk_timeout_max: assert property (fl_cnt_r <= MAX_FLASH)
        else $error("flash outlasted longest timeout");

    cov_flash_start: cover property ($rose(flash_active));
    cov_flash_end: cover property ($fell(flash_active) && hardware_enable_pin);
    cov_shutdown: cover property (flash_active && !hardware_enable_pin);
endmodule : fts_flash_ctrl_props

bind fts_flash_ctrl fts_flash_ctrl_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) fts_flash_ctrl_props_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hardware_enable_pin(hardware_enable_pin),
    .current_source_a_en(current_source_a_en), .current_source_b_en(current_source_b_en),
    .flash_active(flash_active));

// *** tb/fts_pa_model.sv ***
// Behavioural power-amplifier side driving both sync pins
`timescale 1ns/1ns
module fts_pa_model (
    input wire logic sys_clk, // System clock
    input wire logic active_high, // Level that counts as active
    input wire logic want_a, // Request pin A active
    input wire logic want_b, // Request pin B active
    output logic pin_a, // Drives multi_function_pin_a
    output logic pin_b // Drives pa_sync_input_b
);
    // Pins move only on the edge, like the amplifier's registered control
    always_ff @(posedge sys_clk) begin
        pin_a <= want_a ? active_high : !active_high;
        pin_b <= want_b ? active_high : !active_high;
    end
endmodule : fts_pa_model

// *** tb/test_flash_tx_sync_control.sv ***
// Self-checking bench for the flash sync control block
`timescale 1ns/1ns
`include "fts_consts.svh"
`define CHECK_EQ(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module test_flash_tx_sync_control;
    typedef struct {logic [7:0] adr; logic we; logic [7:0] dat; logic [7:0] exp;} fts_row_type;
    localparam int unsigned CYC_MS = 10;
    logic sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, q, a_lvl, b_lvl;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic hw_en, ot, lf, ts, uv, below, pol, want_a, want_b, pin_a, pin_b, a_en, b_en, fl;
    int n_fail = 0;
    int n_checks = 0;
    time t0;
    fts_row_type rows [15] = '{
        '{`FTS_ADDR_CONTROL, 1'b0, 8'h00, `FTS_RST_CONTROL},
        '{`FTS_ADDR_CONFIG1, 1'b0, 8'h00, `FTS_RST_CONFIG1},
        '{`FTS_ADDR_TORCH_LEVEL, 1'b0, 8'h00, `FTS_RST_TORCH_LEVEL},
        '{`FTS_ADDR_FLASH_LEVEL, 1'b0, 8'h00, `FTS_RST_FLASH_LEVEL},
        '{`FTS_ADDR_FLASH_DURATION, 1'b0, 8'h00, `FTS_RST_FLASH_DURATION},
        '{`FTS_ADDR_REDUCED_LEVEL, 1'b0, 8'h00, `FTS_RST_REDUCED_LEVEL},
        '{`FTS_ADDR_FLAGS, 1'b0, 8'h00, 8'h00},
        '{`FTS_ADDR_STATUS, 1'b0, 8'h00, 8'h20},
        '{8'h24, 1'b1, 8'hFF, 8'h00},
        '{`FTS_ADDR_FLASH_DURATION, 1'b1, 8'h1F, 8'h1F},
        '{`FTS_ADDR_FLASH_DURATION, 1'b1, 8'h00, 8'h00},
        '{`FTS_ADDR_TORCH_LEVEL, 1'b1, 8'h21, 8'h21},
        '{`FTS_ADDR_FLASH_LEVEL, 1'b1, 8'hA5, 8'hA5},
        '{`FTS_ADDR_CONTROL, 1'b1, 8'h06, 8'h06},
        '{`FTS_ADDR_CONTROL, 1'b1, 8'h00, 8'h00}};

    fts_flash_ctrl #(.CYCLES_PER_MS(CYC_MS), .LEVEL_W(8)) fts_flash_ctrl_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hardware_enable_pin(hw_en),
        .multi_function_pin_a(pin_a), .pa_sync_input_b(pin_b), .led_overtemp_in(ot),
        .led_fail_in(lf), .thermal_shutdown_in(ts), .supply_undervolt_in(uv),
        .supply_below_flash_th_in(below), .current_source_a_en(a_en),
        .current_source_a_level(a_lvl), .current_source_b_en(b_en),
        .current_source_b_level(b_lvl), .flash_active(fl));

    fts_pa_model fts_pa_model_inst (.sys_clk(sys_clk), .active_high(pol), .want_a(want_a),
        .want_b(want_b), .pin_a(pin_a), .pin_b(pin_b));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Classic single cycle; waits up to 20 cycles for ack, then fails a check
    task automatic wb(input logic [7:0] adr, input logic we, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20) `CHECK_EQ(1'b0, 1'b1, "bus never answered")
    endtask : wb

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : cyc

    // Low nibble feeds source A, high nibble source B
    task automatic lvl(input logic [7:0] v, input string m);
        `CHECK_EQ({a_en, b_en, a_lvl, b_lvl}, {2'b11, 4'h0, v[3:0], 4'h0, v[7:4]}, m)
    endtask : lvl

    task automatic wait_end();
        int c;
        c = 0;
        while (fl === 1'b1 && c < 12000) begin
            @(posedge sys_clk);
            c++;
        end
        if (c >= 12000) `CHECK_EQ(1'b0, 1'b1, "flash never ended")
    endtask : wait_end

    initial begin
        #(20 * 40000);
        n_fail++;
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_sel_i = 4'hF;
        wb_adr_i = 8'h00; wb_dat_i = 32'h00000000; hw_en = 1'b1; ot = 1'b0; lf = 1'b0;
        ts = 1'b0; uv = 1'b0; below = 1'b0; pol = 1'b1; want_a = 1'b0; want_b = 1'b0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(4);
        foreach (rows[i]) begin
            if (rows[i].we)
                wb(rows[i].adr, 1'b1, rows[i].dat);
            wb(rows[i].adr, 1'b0, 8'h00);
            `CHECK_EQ(q, rows[i].exp, "register readback")
        end
        // Shortest timeout, sync A toggled, then left active across the end
        wb(`FTS_ADDR_CONTROL, 1'b1, 8'h01);
        t0 = $time;
        `CHECK_EQ(fl, 1'b1, "flash did not start")
        lvl(8'hA5, "flash level");
        want_a <= 1'b1;
        cyc(5);
        lvl(8'h21, "torch level under sync a");
        want_a <= 1'b0;
        cyc(5);
        lvl(8'hA5, "flash level restored");
        want_a <= 1'b1;
        wait_end();
        `CHECK_EQ(($time - t0) / 20 >= 318 && ($time - t0) / 20 <= 324, 1'b1, "flash length")
        `CHECK_EQ({a_en, b_en}, 2'b00, "sources on after timeout")
        want_a <= 1'b0;
        wb(`FTS_ADDR_FLAGS, 1'b0, 8'h00);
        `CHECK_EQ(q, 8'h21, "timeout and sync a flags")
        wb(`FTS_ADDR_FLAGS, 1'b0, 8'h00);
        `CHECK_EQ(q, 8'h00, "flags not cleared by read")
        // Active-low polarity through sync B, then shutdown in mid-flash
        wb(`FTS_ADDR_CONFIG1, 1'b1, 8'h00);
        pol <= 1'b0;
        cyc(3);
        wb(`FTS_ADDR_CONTROL, 1'b1, 8'h01);
        want_b <= 1'b1;
        cyc(5);
        lvl(8'h21, "torch level under low sync b");
        wb(`FTS_ADDR_FLAGS, 1'b0, 8'h00);
        `CHECK_EQ(q, 8'h80, "sync b flag")
        hw_en <= 1'b0;
        cyc(5);
        `CHECK_EQ({fl, a_en, b_en}, 3'b000, "still driving in shutdown")
        hw_en <= 1'b1;
        want_b <= 1'b0;
        pol <= 1'b1;
        cyc(5);
        wb(`FTS_ADDR_CONFIG1, 1'b0, 8'h00);
        `CHECK_EQ(q, `FTS_RST_CONFIG1, "config not reset by shutdown")
        // Monitor trip holds the reduced level until the flags are read
        wb(`FTS_ADDR_FLASH_DURATION, 1'b1, 8'h00);
        wb(`FTS_ADDR_CONTROL, 1'b1, 8'h05);
        below <= 1'b1;
        cyc(5);
        below <= 1'b0;
        cyc(5);
        lvl(`FTS_RST_REDUCED_LEVEL, "reduced level not held");
        wb(`FTS_ADDR_FLAGS, 1'b0, 8'h00);
        `CHECK_EQ(q, 8'h40, "flash monitor flag")
        cyc(3);
        lvl(`FTS_RST_FLASH_LEVEL, "flash level after flags read");
        {ot, lf, ts, uv} <= 4'hF;
        cyc(4);
        {ot, lf, ts, uv} <= 4'h0;
        wait_end();
        wb(`FTS_ADDR_FLAGS, 1'b0, 8'h00);
        `CHECK_EQ(q, 8'h1F, "fault and timeout flags")
        // Pin A as a torch enable
        wb(`FTS_ADDR_CONFIG1, 1'b1, 8'hA0);
        want_a <= 1'b1;
        cyc(5);
        lvl(`FTS_RST_TORCH_LEVEL, "hardware torch level");
        want_a <= 1'b0;
        cyc(5);
        `CHECK_EQ({a_en, b_en, fl}, 3'b000, "hardware torch stays on")
        // Reset in mid-run while the hardware torch is lit
        want_a <= 1'b1;
        cyc(5);
        sys_rst <= 1'b1;
        cyc(2);
        `CHECK_EQ({a_en, b_en, fl, wb_ack_o}, 4'h0, "outputs on in reset")
        sys_rst <= 1'b0;
        want_a <= 1'b0;
        cyc(4);
        wb(`FTS_ADDR_CONFIG1, 1'b0, 8'h00);
        `CHECK_EQ(q, `FTS_RST_CONFIG1, "config not reset")
        print_verdict();
    end
endmodule : test_flash_tx_sync_control
